//--- hdl/lftr_defs.svh
// Offsets, field positions, reset values and timing counts of the tuning registers
`ifndef LFTR_DEFS_SVH
`define LFTR_DEFS_SVH
`define LFTR_OFS_AZCHK      8'h22
`define LFTR_OFS_GAINDEQ    8'h23
`define LFTR_RST_AZCHK      8'h00
`define LFTR_RST_GAINDEQ    8'hC8
`define LFTR_AZCHK_WMASK    8'hDF
`define LFTR_F_DELAY        7:6
`define LFTR_F_STATUS       5
`define LFTR_F_POLICY       4:3
`define LFTR_F_ON_ERROR_BEHAVIOUR       2
`define LFTR_F_CHECK        1:0
`define LFTR_F_GAIN         7:6
`define LFTR_F_FINAL        5:4
`define LFTR_F_DATA_AUTOZERO_ENABLE         3
`define LFTR_F_RES          2:1
`define LFTR_F_DEQ_ENABLE        0
`define LFTR_CLK_MHZ        100
`define LFTR_HALF_PER_NS    4000
`define LFTR_HALF_CYC       (`LFTR_HALF_PER_NS * `LFTR_CLK_MHZ / 1000)
`define LFTR_3HALF_CYC      (3 * `LFTR_HALF_CYC)
`endif

//--- hdl/lftr_pkg.sv
// Types shared by the tuning register bank
package lftr_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } lftr_bus_req_t;

  typedef struct packed {
    logic [2:0] amp_gain;
    logic [1:0] final_stage;
    logic       fourth_rect_off;
    logic [1:0] deq_resistor;
    logic       deq_enable;
    logic       short_packets;
  } lftr_trim_t;

  typedef enum logic [1:0] {
    AZ_LOW,
    AZ_HIGH,
    AZ_DELAY
  } lftr_az_state_t;
endpackage

//--- hdl/lftr_regs.sv
// Paged auto-zero, carrier-check, gain and de-Q tuning registers with their control logic
// Notes on behaviour
// - Both registers answer at 0x22 and 0x23 only while the page-select bit is set.
// - The release-delay field lags the auto-zero line fall by none, half or 1.5 125 kHz periods.
// - Bit 5 of the first register is read-only and shows whether de-Q is really active.
// - Policy 00 triggers auto-zero after the edge count, 01 adds a random -1, 0 or +1 to it.
// - Policies 10 and 11 also require the demodulated data to be 0 or 1 respectively.
// - On-error bit resets to 0; at 0 an error ends ON time, at 1 it returns to sniff if time remains.
// - Check codes 00 and 11 use 2x32 us packets, 01 and 10 use 8x8 us packets.
// - Gain codes 00 to 11 select gains 2, 3, 4 and 6; reset code is 11.
// - Final-stage 00 is fixed gain 6, 01 programmable gain, 10 and 11 disable the fourth rectifier.
// - Data auto-zero enable permits auto-zero during a data frame and resets to 1.
// - De-Q resistor code runs from the largest value at 00 down to 500 ohms at 11.
// - De-Q enable turns the de-Q system on and resets to 0.
`timescale 1ns/1ps
`include "lftr_defs.svh"

module lftr_regs
  import lftr_pkg::*;
#(
  parameter int HALF_CYC  = `LFTR_HALF_CYC,
  parameter int THALF_CYC = `LFTR_3HALF_CYC
) (
  input  wire logic          ref_clk_in,
  input  wire logic          reset_n_in,
  input  wire lftr_bus_req_t bus_in,
  output logic [7:0]         rdata_out,
  input  wire logic          register_page_select_in,
  input  wire logic [2:0]    az_edge_count_in,
  input  wire logic          data_frame_in,
  input  wire logic          demod_data_in,
  input  wire logic          sum_autozero_enable_in,
  input  wire logic          deq_active_in,
  input  wire logic          rx_error_in,
  input  wire logic          on_time_left_in,
  output logic               az_line_out,
  output logic               az_start_out,
  output logic               end_on_time_out,
  output logic               return_sniff_out,
  output lftr_trim_t         trim_out
);

  logic [7:0]     ctl_azchk;
  logic [7:0]     ctl_gaindeq;
  logic [2:0]     data_sync;
  logic [1:0]     sum_sync;
  logic [1:0]     deq_sync;
  lftr_az_state_t az_state;
  logic [10:0]    delay_cnt;
  logic [3:0]     edge_cnt;
  logic [3:0]     lfsr;
  logic [3:0]     target;
  logic           hit_az;
  logic           hit_gd;
  logic           level_ok;

  function automatic logic [2:0] gain_of(input logic [1:0] code);
    case (code)
      2'b00:   gain_of = 3'd2;
      2'b01:   gain_of = 3'd3;
      2'b10:   gain_of = 3'd4;
      default: gain_of = 3'd6;
    endcase
  endfunction

  // Addresses only decode with the page bit set
  assign hit_az = register_page_select_in && (bus_in.addr == `LFTR_OFS_AZCHK);
  assign hit_gd = register_page_select_in && (bus_in.addr == `LFTR_OFS_GAINDEQ);

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctl_azchk   <= `LFTR_RST_AZCHK;
      ctl_gaindeq <= `LFTR_RST_GAINDEQ;
    end else if (bus_in.wr) begin
      if (hit_az) begin
        ctl_azchk <= bus_in.wdata & `LFTR_AZCHK_WMASK;
      end
      if (hit_gd) begin
        ctl_gaindeq <= bus_in.wdata;
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_out <= 8'h00;
    end else if (bus_in.rd && hit_az) begin
      rdata_out <= ctl_azchk;
      rdata_out[`LFTR_F_STATUS] <= deq_sync[1];
    end else if (bus_in.rd && hit_gd) begin
      rdata_out <= ctl_gaindeq;
    end else begin
      rdata_out <= 8'h00;
    end
  end

  // Analog and pin levels cross in through two flops
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      data_sync <= 3'h0;
      sum_sync  <= 2'h0;
      deq_sync  <= 2'h0;
    end else begin
      data_sync <= {data_sync[1:0], demod_data_in};
      sum_sync  <= {sum_sync[0], sum_autozero_enable_in};
      deq_sync  <= {deq_sync[0], deq_active_in};
    end
  end

  // Release delay: rise passes at once, fall waits the programmed lag
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      az_state    <= AZ_LOW;
      delay_cnt   <= 11'h000;
      az_line_out <= 1'b0;
    end else begin
      case (az_state)
        AZ_LOW: begin
          if (sum_sync[1]) begin
            az_state    <= AZ_HIGH;
            az_line_out <= 1'b1;
          end
        end
        AZ_HIGH: begin
          if (!sum_sync[1]) begin
            if (!ctl_azchk[7]) begin
              az_state    <= AZ_LOW;
              az_line_out <= 1'b0;
            end else begin
              az_state  <= AZ_DELAY;
              // Full count, so the lag adds exactly the programmed cycles
              delay_cnt <= ctl_azchk[6] ? 11'(THALF_CYC) : 11'(HALF_CYC);
            end
          end
        end
        AZ_DELAY: begin
          // A new rise cancels the pending release
          if (sum_sync[1]) begin
            az_state <= AZ_HIGH;
          end else if (delay_cnt == 11'h001) begin
            az_state    <= AZ_LOW;
            az_line_out <= 1'b0;
          end else begin
            delay_cnt <= delay_cnt - 11'h001;
          end
        end
        default: begin
          az_state    <= AZ_LOW;
          az_line_out <= 1'b0;
        end
      endcase
    end
  end

  // Target is the edge count with a random -1/0/+1 under policy 01; never below one
  always_comb begin
    target = {1'b0, az_edge_count_in};
    if (ctl_azchk[`LFTR_F_POLICY] == 2'b01) begin
      target = {1'b0, az_edge_count_in} + {2'b00, (lfsr[1:0] == 2'b11) ? 2'b10 : lfsr[1:0]}
               - 4'h1;
    end
    if (target == 4'h0) begin
      target = 4'h1;
    end
    case (ctl_azchk[`LFTR_F_POLICY])
      2'b10:   level_ok = !data_sync[1];
      2'b11:   level_ok = data_sync[1];
      default: level_ok = 1'b1;
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      edge_cnt     <= 4'h0;
      lfsr         <= 4'h1;
      az_start_out <= 1'b0;
    end else begin
      az_start_out <= 1'b0;
      lfsr         <= {lfsr[2:0], lfsr[3] ^ lfsr[2]};
      if (!data_frame_in) begin
        edge_cnt <= 4'h0;
      end else if (edge_cnt >= target && level_ok && ctl_gaindeq[`LFTR_F_DATA_AUTOZERO_ENABLE]) begin
        az_start_out <= 1'b1;
        edge_cnt     <= 4'h0;
      end else if ((data_sync[1] ^ data_sync[2]) && edge_cnt != 4'hF) begin
        edge_cnt <= edge_cnt + 4'h1;
      end
    end
  end

  // Error handling during ON time
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      end_on_time_out  <= 1'b0;
      return_sniff_out <= 1'b0;
    end else begin
      return_sniff_out <= rx_error_in && ctl_azchk[`LFTR_F_ON_ERROR_BEHAVIOUR] && on_time_left_in;
      end_on_time_out  <= rx_error_in && !(ctl_azchk[`LFTR_F_ON_ERROR_BEHAVIOUR] && on_time_left_in);
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      trim_out <= '0;
    end else begin
      trim_out.amp_gain        <= gain_of(ctl_gaindeq[`LFTR_F_GAIN]);
      trim_out.final_stage     <= ctl_gaindeq[`LFTR_F_FINAL];
      trim_out.fourth_rect_off <= ctl_gaindeq[5];
      trim_out.deq_resistor    <= ctl_gaindeq[`LFTR_F_RES];
      trim_out.deq_enable      <= ctl_gaindeq[`LFTR_F_DEQ_ENABLE];
      trim_out.short_packets   <= ^ctl_azchk[`LFTR_F_CHECK];
    end
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);

  a_page_read_gate: assert property (
    bus_in.rd && !register_page_select_in |=> rdata_out == 8'h00)
    else $error("read answered with page bit clear");
  a_page_write_gate: assert property (
    bus_in.wr && !register_page_select_in |=> $stable(ctl_azchk) && $stable(ctl_gaindeq))
    else $error("write taken with page bit clear");
  a_release_nodelay: assert property (
    az_state == AZ_HIGH && !sum_sync[1] && !ctl_azchk[7] |=> !az_line_out)
    else $error("release delayed with delay code 0x");
  a_release_hold: assert property (
    az_state == AZ_DELAY |-> az_line_out)
    else $error("az line fell before delay expired");
  a_status_read: assert property (
    bus_in.rd && hit_az |=> rdata_out[5] == $past(deq_sync[1]))
    else $error("status bit does not follow de-Q activity");
  a_status_ro_write: assert property (
    bus_in.wr && hit_az |=> !ctl_azchk[5] && ctl_azchk[7:6] == $past(bus_in.wdata[7:6]))
    else $error("status bit stored or fields lost");
  a_trigger_level: assert property (
    az_start_out && $past(ctl_azchk[4]) |-> $past(data_sync[1]) == $past(ctl_azchk[3]))
    else $error("auto-zero started at wrong data level");
  a_trigger_gate: assert property (
    !ctl_gaindeq[3] && $stable(ctl_gaindeq) |=> !az_start_out)
    else $error("auto-zero started while disabled");
  a_error_sniff: assert property (
    rx_error_in && ctl_azchk[2] && on_time_left_in |=> return_sniff_out && !end_on_time_out)
    else $error("error did not return to sniff");
  a_gain_decode: assert property (
    ctl_gaindeq[7:6] == 2'b11 |=> trim_out.amp_gain == 3'd6)
    else $error("gain code 11 not decoded as 6");
  a_gain_lowest: assert property (
    ctl_gaindeq[7:6] == 2'b00 |=> trim_out.amp_gain == 3'd2)
    else $error("gain code 00 not decoded as 2");

  // Bus decode
  a_gd_write: assert property (
    bus_in.wr && hit_gd |=> ctl_gaindeq == $past(bus_in.wdata))
    else $error("gain register write lost");
  a_gd_read: assert property (
    bus_in.rd && hit_gd |=> rdata_out == $past(ctl_gaindeq))
    else $error("gain register read wrong");
  a_read_idle: assert property (
    !bus_in.rd |=> rdata_out == 8'h00)
    else $error("read data shown without a read");

  // Release delay sequencing
  a_release_rise: assert property (
    az_state == AZ_LOW && sum_sync[1] |=> az_line_out)
    else $error("az line did not follow enable rise");
  a_delay_load: assert property (
    az_state == AZ_HIGH && !sum_sync[1] && ctl_azchk[7]
    |=> az_state == AZ_DELAY && delay_cnt == ($past(ctl_azchk[6]) ? 11'(THALF_CYC) : 11'(HALF_CYC)))
    else $error("release delay loaded wrong");
  a_delay_count: assert property (
    az_state == AZ_DELAY && !sum_sync[1] && delay_cnt != 11'h001
    |=> delay_cnt == $past(delay_cnt) - 11'h001)
    else $error("release delay did not count down");

  // Trigger policy
  a_trigger_count: assert property (
    az_start_out |-> $past(edge_cnt) >= $past(target))
    else $error("auto-zero started before edge count");
  a_target_range: assert property (
    ctl_azchk[4:3] == 2'b01 && az_edge_count_in != 3'h0
    |-> target + 4'h1 >= {1'b0, az_edge_count_in} && target <= {1'b0, az_edge_count_in} + 4'h1)
    else $error("random offset outside one edge");
  a_edge_clear: assert property (
    !data_frame_in |=> edge_cnt == 4'h0)
    else $error("edge count kept outside frame");

  // Error handling
  a_error_end: assert property (
    rx_error_in && !(ctl_azchk[2] && on_time_left_in) |=> end_on_time_out && !return_sniff_out)
    else $error("error did not end on time");
  a_error_quiet: assert property (
    !rx_error_in |=> !end_on_time_out && !return_sniff_out)
    else $error("error outputs without an error");

  // Trim decode
  a_check_short: assert property (
    ctl_azchk[1:0] == 2'b01 || ctl_azchk[1:0] == 2'b10 |=> trim_out.short_packets)
    else $error("check codes 01 or 10 not short packets");
  a_check_long: assert property (
    ctl_azchk[1:0] == 2'b00 || ctl_azchk[1:0] == 2'b11 |=> !trim_out.short_packets)
    else $error("check codes 00 or 11 not long packets");
  a_final_rect: assert property (
    ctl_gaindeq[5] |=> trim_out.fourth_rect_off)
    else $error("fourth rectifier not disabled");
  a_deq_resistor: assert property (
    ##1 trim_out.deq_resistor == $past(ctl_gaindeq[2:1]))
    else $error("de-Q resistor code not passed on");
  a_deq_enable: assert property (
    ##1 trim_out.deq_enable == $past(ctl_gaindeq[0]))
    else $error("de-Q enable not passed on");

endmodule  // lftr_regs

//--- verification/lftr_afe_model.sv
// Analog front end stand-in that reports de-Q activity
`timescale 1ns/1ps
module lftr_afe_model
  import lftr_pkg::*;
(
  input  wire logic       ref_clk_in,
  input  wire lftr_trim_t trim_in,
  output logic            deq_active_out
);
  logic [2:0] lag;
  // Analog settling, so status trails the enable
  always_ff @(posedge ref_clk_in) begin
    lag <= {lag[1:0], trim_in.deq_enable};
  end
  assign deq_active_out = lag[2];
endmodule // lftr_afe_model

//--- verification/lftr_regs_tb.sv
// Self-checking bench for the tuning register bank
`timescale 1ns/1ps
module lftr_regs_tb
  import lftr_pkg::*;
;
  logic          clk, rst_n, page, frame, demod, sum_az, err, left;
  logic          az_line, az_start, end_on, sniff, deq_act;
  logic [7:0]    rdata;
  lftr_bus_req_t bus;
  lftr_trim_t    trim;
  int            failures, checks_done, cyc, starts;

  // Short delay counts keep the run brief
  lftr_regs #(.HALF_CYC(4), .THALF_CYC(12)) i_lftr_regs (
    .ref_clk_in(clk), .reset_n_in(rst_n), .bus_in(bus), .rdata_out(rdata),
    .register_page_select_in(page), .az_edge_count_in(3'h6),
    .data_frame_in(frame), .demod_data_in(demod), .sum_autozero_enable_in(sum_az),
    .deq_active_in(deq_act), .rx_error_in(err), .on_time_left_in(left),
    .az_line_out(az_line), .az_start_out(az_start), .end_on_time_out(end_on),
    .return_sniff_out(sniff), .trim_out(trim));
  lftr_afe_model i_lftr_afe_model (.ref_clk_in(clk), .trim_in(trim), .deq_active_out(deq_act));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus <= '{a, d, 1'b0, 1'b0};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    bus <= '{a, 8'h00, 1'b0, 1'b0};
    #1 d = rdata;
  endtask
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic test_regs();
    logic [7:0] d;
    int gains[4] = '{2, 3, 4, 6};
    rd(8'h22, d);
    chk(d, 8'h00);
    rd(8'h23, d);
    chk(d, 8'hC8);
    @(posedge clk);
    page <= 1'b0;
    wr(8'h22, 8'hFF);
    @(posedge clk);
    page <= 1'b1;
    rd(8'h22, d);
    chk(d, 8'h00);
    wr(8'h22, 8'hFF);
    rd(8'h22, d);
    chk(d, 8'hDF);
    wr(8'h23, 8'h01);
    repeat (8) @(posedge clk);
    rd(8'h22, d);
    chk(d, 8'hFF);
    chk(8'(trim.deq_enable), 8'h01);
    for (int k = 0; k < 4; k++) begin
      wr(8'h22, 8'(k));
      wr(8'h23, 8'(k << 6 | k << 4 | 8 | k << 1));
      repeat (2) @(posedge clk);
      #1 chk(8'(trim.amp_gain), 8'(gains[k]));
      chk(8'(trim.final_stage), 8'(k));
      chk(8'(trim.fourth_rect_off), 8'(k >> 1));
      chk(8'(trim.deq_resistor), 8'(k));
      chk(8'(trim.short_packets), 8'(k == 1 || k == 2));
      rd(8'h23, d);
      chk(d, 8'(k << 6 | k << 4 | 8 | k << 1));
    end
    $display("Register test done");
  endtask

  task automatic test_delay();
    for (int c = 0; c < 4; c++) begin
      wr(8'h22, 8'(c << 6));
      @(posedge clk);
      sum_az <= 1'b1;
      repeat (6) @(posedge clk);
      sum_az <= 1'b0;
      repeat (4) @(posedge clk);
      #1 chk(8'(az_line), 8'(c >> 1));
      repeat (6) @(posedge clk);
      #1 chk(8'(az_line), 8'(c == 3));
      repeat (10) @(posedge clk);
      #1 chk(8'(az_line), 8'h00);
    end
    $display("Release delay test done");
  endtask

  task automatic test_trigger();
    int pol[5] = '{0, 1, 2, 3, 0};
    int edges[5] = '{6, 8, 6, 6, 8};
    int exp[5] = '{1, 1, 1, 0, 0};
    for (int i = 0; i < 5; i++) begin
      wr(8'h22, 8'(pol[i] << 3));
      wr(8'h23, (i < 4) ? 8'hC8 : 8'hC0);
      starts = 0;
      @(posedge clk);
      frame <= 1'b1;
      for (int e = 0; e < edges[i]; e++) begin
        repeat (4) @(posedge clk);
        demod <= ~demod;
      end
      repeat (10) @(posedge clk);
      frame <= 1'b0;
      chk(8'(starts), 8'(exp[i]));
    end
    $display("Trigger test done");
  endtask

  task automatic test_error();
    int om[3] = '{0, 1, 1};
    int lf[3] = '{1, 1, 0};
    for (int i = 0; i < 3; i++) begin
      wr(8'h22, 8'(om[i] << 2));
      @(posedge clk);
      err <= 1'b1;
      left <= 1'(lf[i]);
      @(posedge clk);
      err <= 1'b0;
      #1 chk(8'({end_on, sniff}), (om[i] == 1 && lf[i] == 1) ? 8'h01 : 8'h02);
    end
    $display("Error test done");
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (az_start === 1'b1)
      starts++;
    if (cyc == 5000) begin
      failures++;
      summarize();
    end
  end
  initial begin
    {rst_n, frame, demod, sum_az, err, left} = '0;
    page = 1'b1;
    bus = '0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    test_regs();
    test_delay();
    test_trigger();
    test_error();
    summarize();
  end
endmodule // lftr_regs_tb
